//--- banked_cpu_register_file.v
`timescale 1ns/100ps
`include "cpu_regs_map.vh"

module banked_cpu_register_file #(
  parameter WIDTH = 32
) (
  // Clock and resets
  input  wire               mclk_i,
  input  wire               arst_n_i,
  input  wire               manual_rst_i,
  // General register port
  input  wire [3:0]         gpr_rd_idx_i,
  output wire [WIDTH-1:0]   gpr_rd_data_o,
  input  wire               gpr_wr_en_i,
  input  wire [3:0]         gpr_wr_idx_i,
  input  wire [WIDTH-1:0]   gpr_wr_data_i,
  // Other low bank, reached by control load/store
  input  wire               alt_rd_en_i,
  input  wire [2:0]         alt_rd_idx_i,
  output wire [WIDTH-1:0]   alt_rd_data_o,
  input  wire               alt_wr_en_i,
  input  wire [2:0]         alt_wr_idx_i,
  input  wire [WIDTH-1:0]   alt_wr_data_i,
  // Control and system register port
  input  wire [3:0]         ctl_sel_i,
  input  wire               ctl_rd_en_i,
  input  wire               ctl_wr_en_i,
  input  wire [WIDTH-1:0]   ctl_wr_data_i,
  output reg  [WIDTH-1:0]   ctl_rd_data_o,
  output reg                access_fault_o,
  // Program counter advance
  input  wire               pc_load_i,
  input  wire [WIDTH-1:0]   pc_next_i,
  // Floating-point port
  input  wire               fp_bank_sel_i,
  input  wire               fp_rd_ext_i,
  input  wire [3:0]         fp_rd_idx_i,
  input  wire [1:0]         fp_rd_view_i,
  output reg  [4*WIDTH-1:0] fp_rd_data_o,
  input  wire               fp_wr_en_i,
  input  wire               fp_wr_pair_i,
  input  wire               fp_wr_ext_i,
  input  wire [3:0]         fp_wr_idx_i,
  input  wire [2*WIDTH-1:0] fp_wr_data_i,
  // Status outputs
  output wire               privilege_bit_o,
  output wire               bank_select_bit_o,
  output wire               event_hold_flag_o,
  output wire               fpu_off_bit_o,
  output wire [3:0]         irq_level_mask_o,
  output wire [WIDTH-1:0]   pc_o,
  output wire [WIDTH-1:0]   fp_status_ctrl_o
);

  // ----------------------------------------
  // Reset-valued registers
  // ----------------------------------------
  reg  [WIDTH-1:0] status_word;
  reg  [WIDTH-1:0] vector_base;
  reg  [WIDTH-1:0] pc;
  reg  [WIDTH-1:0] fp_status_ctrl;

  // ----------------------------------------
  // Registers with no reset value
  // ----------------------------------------
  reg  [WIDTH-1:0] global_base;
  reg  [WIDTH-1:0] saved_status;
  reg  [WIDTH-1:0] saved_pc;
  reg  [WIDTH-1:0] saved_r15;
  reg  [WIDTH-1:0] debug_base;
  reg  [WIDTH-1:0] mac_high;
  reg  [WIDTH-1:0] mac_low;
  reg  [WIDTH-1:0] subroutine_link;
  reg  [WIDTH-1:0] fp_cpu_transfer;

  wire             priv_mode;
  wire             live_bank;
  wire             ctl_access;
  reg              sel_priv_only;
  reg              sel_mapped;
  wire             ctl_allowed;
  wire             ctl_wr_ok;
  wire             alt_ok;
  reg  [WIDTH-1:0] next_ctl_rd_data;
  reg  [WIDTH-1:0] next_status_word;

  // ----------------------------------------
  // Mode and bank decode
  // ----------------------------------------
  assign priv_mode = status_word[`SW_PRIVILEGE_BIT];
  // User mode always sees bank zero as the live low bank
  assign live_bank = priv_mode & status_word[`SW_BANK_SELECT_BIT];

  assign privilege_bit_o   = status_word[`SW_PRIVILEGE_BIT];
  assign bank_select_bit_o = status_word[`SW_BANK_SELECT_BIT];
  assign event_hold_flag_o = status_word[`SW_EVENT_HOLD_FLAG];
  assign fpu_off_bit_o     = status_word[`SW_FPU_OFF_BIT];
  assign irq_level_mask_o  = status_word[`SW_IRQ_MASK_HI:`SW_IRQ_MASK_LO];
  assign pc_o              = pc;
  assign fp_status_ctrl_o  = fp_status_ctrl;

  // ----------------------------------------
  // General registers
  // ----------------------------------------
  wire [4:0] gpr_rd_phys;
  wire [4:0] gpr_wr_phys;
  wire [4:0] alt_rd_phys;
  wire [4:0] alt_wr_phys;
  wire       store_wr_en;
  wire [4:0] store_wr_addr;
  wire [WIDTH-1:0] store_wr_data;

  // Low indices pick a bank of eight; high ones land on entries 16-23
  assign gpr_rd_phys = gpr_rd_idx_i[3] ? {2'b10, gpr_rd_idx_i[2:0]}
                                       : {1'b0, live_bank, gpr_rd_idx_i[2:0]};
  assign gpr_wr_phys = gpr_wr_idx_i[3] ? {2'b10, gpr_wr_idx_i[2:0]}
                                       : {1'b0, live_bank, gpr_wr_idx_i[2:0]};
  assign alt_rd_phys = {1'b0, priv_mode & ~live_bank, alt_rd_idx_i};
  assign alt_wr_phys = {1'b0, ~live_bank, alt_wr_idx_i};
  // Alternate bank exists only in privileged mode; user mode cannot reach bank one
  assign alt_ok = priv_mode;

  // Single write port: a normal write wins over an alternate-bank write
  assign store_wr_en   = gpr_wr_en_i | (alt_wr_en_i & alt_ok);
  assign store_wr_addr = gpr_wr_en_i ? gpr_wr_phys : alt_wr_phys;
  assign store_wr_data = gpr_wr_en_i ? gpr_wr_data_i : alt_wr_data_i;

  gpr_store #(
    .WIDTH (WIDTH),
    .DEPTH (24),
    .AW    (5)
  ) u_gpr_store (
    .mclk_i      (mclk_i),
    .wr_en_i     (store_wr_en),
    .wr_addr_i   (store_wr_addr),
    .wr_data_i   (store_wr_data),
    .rd_a_addr_i (gpr_rd_phys),
    .rd_a_data_o (gpr_rd_data_o),
    .rd_b_addr_i (alt_rd_phys),
    .rd_b_data_o (alt_rd_data_o)
  );

  // ----------------------------------------
  // Control and system register access
  // ----------------------------------------
  assign ctl_access = ctl_rd_en_i | ctl_wr_en_i;

  always @* begin
    sel_priv_only = 1'b0;
    sel_mapped    = 1'b1;
    case (ctl_sel_i)
      `SEL_STATUS_WORD,
      `SEL_GLOBAL_BASE:     sel_priv_only = 1'b0;
      `SEL_SAVED_STATUS,
      `SEL_SAVED_PC,
      `SEL_VECTOR_BASE,
      `SEL_SAVED_R15,
      `SEL_DEBUG_BASE:      sel_priv_only = 1'b1;
      `SEL_MAC_HIGH,
      `SEL_MAC_LOW,
      `SEL_SUBROUTINE_LINK,
      `SEL_PC,
      `SEL_FP_CPU_TRANSFER,
      `SEL_FP_STATUS_CTRL:  sel_priv_only = 1'b0;
      default:              sel_mapped    = 1'b0;
    endcase
  end

  assign ctl_allowed = sel_mapped & (priv_mode | ~sel_priv_only);
  assign ctl_wr_ok   = ctl_wr_en_i & ctl_allowed;

  // User writes keep the privileged-only fields as they were
  always @* begin
    if (priv_mode) begin
      next_status_word = ctl_wr_data_i & `SW_PRIV_MASK;
    end else begin
      next_status_word = (status_word & ~`SW_USER_MASK)
                       | (ctl_wr_data_i & `SW_USER_MASK);
    end
  end

  always @* begin
    next_ctl_rd_data = {WIDTH{1'b0}};
    if (ctl_rd_en_i && ctl_allowed) begin
      case (ctl_sel_i)
        // Privileged-only fields read as zero from user mode
        `SEL_STATUS_WORD:     next_ctl_rd_data = priv_mode ? status_word
                                               : (status_word & `SW_USER_MASK);
        `SEL_GLOBAL_BASE:     next_ctl_rd_data = global_base;
        `SEL_SAVED_STATUS:    next_ctl_rd_data = saved_status;
        `SEL_SAVED_PC:        next_ctl_rd_data = saved_pc;
        `SEL_VECTOR_BASE:     next_ctl_rd_data = vector_base;
        `SEL_SAVED_R15:       next_ctl_rd_data = saved_r15;
        `SEL_DEBUG_BASE:      next_ctl_rd_data = debug_base;
        `SEL_MAC_HIGH:        next_ctl_rd_data = mac_high;
        `SEL_MAC_LOW:         next_ctl_rd_data = mac_low;
        `SEL_SUBROUTINE_LINK: next_ctl_rd_data = subroutine_link;
        `SEL_PC:              next_ctl_rd_data = pc;
        `SEL_FP_CPU_TRANSFER: next_ctl_rd_data = fp_cpu_transfer;
        `SEL_FP_STATUS_CTRL:  next_ctl_rd_data = fp_status_ctrl;
        default:              next_ctl_rd_data = {WIDTH{1'b0}};
      endcase
    end
  end

  // ----------------------------------------
  // Reset-valued state, power-on and manual
  // ----------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_word    <= `RST_STATUS_WORD;
      vector_base    <= `RST_VECTOR_BASE;
      pc             <= `RST_PC;
      fp_status_ctrl <= `RST_FP_STATUS_CTRL;
      ctl_rd_data_o  <= {WIDTH{1'b0}};
      access_fault_o <= 1'b0;
    end else if (manual_rst_i) begin
      status_word    <= `RST_STATUS_WORD;
      vector_base    <= `RST_VECTOR_BASE;
      pc             <= `RST_PC;
      fp_status_ctrl <= `RST_FP_STATUS_CTRL;
      ctl_rd_data_o  <= {WIDTH{1'b0}};
      access_fault_o <= 1'b0;
    end else begin
      ctl_rd_data_o  <= next_ctl_rd_data;
      // Refused control access or alternate bank touched from user mode
      access_fault_o <= (ctl_access & ~ctl_allowed)
                      | ((alt_rd_en_i | alt_wr_en_i) & ~alt_ok);
      if (ctl_wr_ok && ctl_sel_i == `SEL_STATUS_WORD) begin
        status_word <= next_status_word;
      end
      if (ctl_wr_ok && ctl_sel_i == `SEL_VECTOR_BASE) begin
        vector_base <= ctl_wr_data_i;
      end
      // Software write to pc beats the sequential advance
      if (ctl_wr_ok && ctl_sel_i == `SEL_PC) begin
        pc <= ctl_wr_data_i;
      end else if (pc_load_i) begin
        pc <= pc_next_i;
      end
      if (ctl_wr_ok && ctl_sel_i == `SEL_FP_STATUS_CTRL) begin
        fp_status_ctrl <= ctl_wr_data_i;
      end
    end
  end

  // Left unreset: contents are undefined after reset anyway
  always @(posedge mclk_i) begin
    if (ctl_wr_ok) begin
      case (ctl_sel_i)
        `SEL_GLOBAL_BASE:     global_base     <= ctl_wr_data_i;
        `SEL_SAVED_STATUS:    saved_status    <= ctl_wr_data_i;
        `SEL_SAVED_PC:        saved_pc        <= ctl_wr_data_i;
        `SEL_SAVED_R15:       saved_r15       <= ctl_wr_data_i;
        `SEL_DEBUG_BASE:      debug_base      <= ctl_wr_data_i;
        `SEL_MAC_HIGH:        mac_high        <= ctl_wr_data_i;
        `SEL_MAC_LOW:         mac_low         <= ctl_wr_data_i;
        `SEL_SUBROUTINE_LINK: subroutine_link <= ctl_wr_data_i;
        `SEL_FP_CPU_TRANSFER: fp_cpu_transfer <= ctl_wr_data_i;
        default:              ;
      endcase
    end
  end

  // ----------------------------------------
  // Floating-point registers
  // ----------------------------------------
  wire [4:0]       fp_rd_phys;
  wire [4:0]       fp_wr_phys;
  wire [4*WIDTH-1:0] fp_row;
  reg  [1:0]       fp_view_q;
  reg  [1:0]       fp_lane_q;

  // Bank select swaps which physical half is primary and which extended
  assign fp_rd_phys = {fp_rd_ext_i ^ fp_bank_sel_i, fp_rd_idx_i};
  assign fp_wr_phys = {fp_wr_ext_i ^ fp_bank_sel_i, fp_wr_idx_i};

  fp_store #(
    .WIDTH (WIDTH)
  ) u_fp_store (
    .mclk_i        (mclk_i),
    .wr_en_i       (fp_wr_en_i),
    .wr_pair_i     (fp_wr_pair_i),
    .wr_addr_i     (fp_wr_phys),
    .wr_data_i     (fp_wr_data_i),
    .rd_row_i      (fp_rd_phys[4:2]),
    .rd_row_data_o (fp_row)
  );

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fp_view_q <= `FP_VIEW_SINGLE;
      fp_lane_q <= 2'h0;
    end else begin
      fp_view_q <= fp_rd_view_i;
      fp_lane_q <= fp_rd_idx_i[1:0];
    end
  end

  // Views are left-aligned: first register of the group in the top word
  always @* begin
    case (fp_view_q)
      `FP_VIEW_PAIR:
        fp_rd_data_o = {(fp_lane_q[1] ? fp_row[2*WIDTH-1:0]
                                      : fp_row[4*WIDTH-1:2*WIDTH]),
                        {(2*WIDTH){1'b0}}};
      `FP_VIEW_QUAD:
        fp_rd_data_o = fp_row;
      default:
        fp_rd_data_o = {fp_row[(4-fp_lane_q)*WIDTH-1 -: WIDTH],
                        {(3*WIDTH){1'b0}}};
    endcase
  end

endmodule // banked_cpu_register_file

//--- banked_cpu_register_file_bench.sv
`timescale 1ns/100ps
`include "cpu_regs_map.vh"

module banked_cpu_register_file_bench;
  localparam W = 32;
  reg             mclk_i, arst_n_i, manual_rst_i, gpr_wr_en_i, alt_rd_en_i, alt_wr_en_i;
  reg             pc_load_i, fp_bank_sel_i, fp_rd_ext_i, fp_wr_en_i, fp_wr_pair_i, fp_wr_ext_i;
  reg  [3:0]      gpr_rd_idx_i, gpr_wr_idx_i, fp_rd_idx_i, fp_wr_idx_i;
  reg  [2:0]      alt_rd_idx_i, alt_wr_idx_i;
  reg  [1:0]      fp_rd_view_i;
  reg  [W-1:0]    gpr_wr_data_i, alt_wr_data_i, pc_next_i, rd;
  reg  [2*W-1:0]  fp_wr_data_i;
  wire [3:0]      ctl_sel_i, irq_level_mask_o;
  wire            ctl_rd_en_i, ctl_wr_en_i, access_fault_o, privilege_bit_o;
  wire            bank_select_bit_o, event_hold_flag_o, fpu_off_bit_o;
  wire [W-1:0]    ctl_wr_data_i, ctl_rd_data_o, gpr_rd_data_o, alt_rd_data_o, pc_o;
  wire [W-1:0]    fp_status_ctrl_o;
  wire [4*W-1:0]  fp_rd_data_o;
  reg             flt;
  reg  [3:0]      csel;
  integer         n_mismatch, total_checks, cycles, i;

  banked_cpu_register_file #(.WIDTH(W)) i_banked_cpu_register_file (.*);
  decode_stub #(.WIDTH(W)) i_decode_stub (.mclk_i(mclk_i), .ctl_sel_o(ctl_sel_i),
    .ctl_rd_en_o(ctl_rd_en_i), .ctl_wr_en_o(ctl_wr_en_i), .ctl_wr_data_o(ctl_wr_data_i),
    .ctl_rd_data_i(ctl_rd_data_o), .access_fault_i(access_fault_o));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task chk_word(input [8*12-1:0] name, input [W-1:0] exp, input [W-1:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk_wide(input [8*12-1:0] name, input [4*W-1:0] exp, input [4*W-1:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task ctl_chk(input wr, input [3:0] sel, input [W-1:0] data, input [W-1:0] exp, input ef);
    begin
      i_decode_stub.access(wr, sel, data, rd, flt);
      if (!wr) chk_word("ctl read", exp, rd);
      chk_word("ctl fault", {31'h0, ef}, {31'h0, flt});
    end
  endtask
  task status_chk(input [7:0] exp);
    chk_word("status bits", {24'h0, exp}, {24'h0, privilege_bit_o, bank_select_bit_o,
      event_hold_flag_o, fpu_off_bit_o, irq_level_mask_o});
  endtask
  task gpr_wr(input alt, input [3:0] idx, input [W-1:0] data);
    begin
      @(posedge mclk_i);
      #1;
      {gpr_wr_en_i, gpr_wr_idx_i, gpr_wr_data_i} = {!alt, idx, data};
      {alt_wr_en_i, alt_wr_idx_i, alt_wr_data_i} = {alt, idx[2:0], data};
      @(posedge mclk_i);
      #1;
      {gpr_wr_en_i, alt_wr_en_i} = 2'b00;
    end
  endtask
  task gpr_chk(input alt, input [3:0] idx, input [W-1:0] exp);
    begin
      @(posedge mclk_i);
      #1;
      {alt_rd_en_i, alt_rd_idx_i, gpr_rd_idx_i} = {alt, idx[2:0], idx};
      @(posedge mclk_i);
      #1;
      alt_rd_en_i = 1'b0;
      chk_word("gpr read", exp, alt ? alt_rd_data_o : gpr_rd_data_o);
    end
  endtask
  task fp_wr(input pr, input ext, input [3:0] idx, input [2*W-1:0] data);
    begin
      @(posedge mclk_i);
      #1;
      {fp_wr_en_i, fp_wr_pair_i, fp_wr_ext_i, fp_wr_idx_i, fp_wr_data_i} = {1'b1, pr, ext, idx, data};
      @(posedge mclk_i);
      #1;
      fp_wr_en_i = 1'b0;
    end
  endtask
  task fp_chk(input bsel, input ext, input [1:0] view, input [3:0] idx, input [4*W-1:0] exp);
    begin
      @(posedge mclk_i);
      #1;
      {fp_bank_sel_i, fp_rd_ext_i, fp_rd_view_i, fp_rd_idx_i} = {bsel, ext, view, idx};
      @(posedge mclk_i);
      #1;
      // Pair view zero-fills the low half; only the top half is compared
      chk_wide("fp read", exp, view == `FP_VIEW_PAIR ? {fp_rd_data_o[127:64], 64'h0} : fp_rd_data_o);
    end
  endtask
  task mrst;
    begin
      @(posedge mclk_i);
      #1;
      manual_rst_i = 1'b1;
      @(posedge mclk_i);
      #1;
      manual_rst_i = 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {n_mismatch, total_checks, cycles} = 96'h0;
    {arst_n_i, manual_rst_i, gpr_wr_en_i, alt_rd_en_i, alt_wr_en_i, pc_load_i} = 6'h00;
    {fp_bank_sel_i, fp_rd_ext_i, fp_wr_en_i, fp_wr_pair_i, fp_wr_ext_i, fp_rd_view_i} = 7'h00;
    {gpr_rd_idx_i, gpr_wr_idx_i, fp_rd_idx_i, fp_wr_idx_i, alt_rd_idx_i, alt_wr_idx_i} = 22'h0;
    {gpr_wr_data_i, alt_wr_data_i, pc_next_i, fp_wr_data_i} = 160'h0;
    repeat (16) @(posedge mclk_i);
    #1;
    arst_n_i = 1'b1;
    status_chk(8'hE0 | 8'h0F);
    chk_word("pc", 32'hA0000000, pc_o);
    chk_word("fp status", 32'h00040001, fp_status_ctrl_o);
    ctl_chk(0, `SEL_VECTOR_BASE, 0, 32'h00000000, 0);
    ctl_chk(0, `SEL_FP_STATUS_CTRL, 0, 32'h00040001, 0);
    $display("test reset values done");
    gpr_wr(0, 4'h3, 32'hA1A1A1A1);
    gpr_wr(1, 4'h3, 32'hB0B0B0B0);
    gpr_wr(0, 4'h9, 32'hC9C9C9C9);
    gpr_chk(0, 4'h3, 32'hA1A1A1A1);
    gpr_chk(1, 4'h3, 32'hB0B0B0B0);
    ctl_chk(1, `SEL_STATUS_WORD, 32'h400000F0, 0, 0);
    gpr_chk(0, 4'h3, 32'hB0B0B0B0);
    gpr_chk(1, 4'h3, 32'hA1A1A1A1);
    ctl_chk(1, `SEL_STATUS_WORD, 32'h000000F0, 0, 0);
    status_chk(8'h0F);
    gpr_chk(0, 4'h3, 32'hB0B0B0B0);
    gpr_chk(0, 4'h9, 32'hC9C9C9C9);
    gpr_wr(1, 4'h3, 32'hDEADBEEF);
    chk_word("alt fault", 32'h1, {31'h0, access_fault_o});
    gpr_chk(1, 4'h3, 32'hB0B0B0B0);
    $display("test banking done");
    ctl_chk(1, `SEL_STATUS_WORD, 32'hFFFFFFFF, 0, 0);
    status_chk(8'h0F);
    ctl_chk(0, `SEL_STATUS_WORD, 0, 32'h00000303, 0);
    for (i = 2; i <= 6; i = i + 1) begin
      ctl_chk(1, i[3:0], 32'h11111111, 0, 1);
      ctl_chk(0, i[3:0], 0, 32'h00000000, 1);
    end
    for (i = 0; i < 5; i = i + 1) begin
      csel = (i == 0) ? 4'h1 : (i == 4) ? 4'hB : i[3:0] + 4'h6;
      ctl_chk(1, csel, {8{csel}}, 0, 0);
      ctl_chk(0, csel, 0, {8{csel}}, 0);
    end
    ctl_chk(1, `SEL_PC, 32'h80000100, 0, 0);
    chk_word("pc", 32'h80000100, pc_o);
    {pc_load_i, pc_next_i} = {1'b1, 32'h80000104};
    @(posedge mclk_i);
    #1 pc_load_i = 1'b0;
    chk_word("pc", 32'h80000104, pc_o);
    mrst;
    status_chk(8'hEF);
    chk_word("pc", 32'hA0000000, pc_o);
    gpr_chk(0, 4'h3, 32'hA1A1A1A1);
    for (i = 2; i <= 6; i = i + 1) begin
      ctl_chk(1, i[3:0], 32'h22220000 + i, 0, 0);
      ctl_chk(0, i[3:0], 0, 32'h22220000 + i, 0);
    end
    ctl_chk(0, 4'hD, 0, 32'h00000000, 1);
    $display("test mode access done");
    fp_wr(1, 0, 4'h0, 64'h1000000011000000);
    fp_wr(1, 0, 4'h2, 64'h1200000013000000);
    fp_wr(1, 1, 4'h4, 64'hE4000000E5000000);
    fp_wr(1, 1, 4'h6, 64'hE6000000E7000000);
    fp_wr(0, 0, 4'h5, 64'h0000000015000000);
    fp_chk(0, 0, `FP_VIEW_SINGLE, 4'h5, {32'h15000000, 96'h0});
    fp_chk(0, 0, `FP_VIEW_QUAD, 4'h3, 128'h10000000110000001200000013000000);
    fp_chk(0, 0, `FP_VIEW_PAIR, 4'h3, {64'h1200000013000000, 64'h0});
    fp_chk(0, 1, `FP_VIEW_QUAD, 4'h4, 128'hE4000000E5000000E6000000E7000000);
    fp_chk(1, 0, `FP_VIEW_PAIR, 4'h4, {64'hE4000000E5000000, 64'h0});
    fp_chk(1, 1, `FP_VIEW_PAIR, 4'h0, {64'h1000000011000000, 64'h0});
    $display("test fp views done");
    give_verdict;
  end
endmodule // banked_cpu_register_file_bench

//--- cpu_regs_checker.sv
`timescale 1ns/100ps
`include "cpu_regs_map.vh"

module cpu_regs_checker #(
  parameter WIDTH = 32
) (
  // Clock and resets
  input wire             mclk_i,
  input wire             arst_n_i,
  input wire             manual_rst_i,
  // Requests
  input wire [3:0]       ctl_sel_i,
  input wire             ctl_rd_en_i,
  input wire             ctl_wr_en_i,
  input wire [WIDTH-1:0] ctl_wr_data_i,
  input wire             alt_wr_en_i,
  // Results
  input wire [WIDTH-1:0] ctl_rd_data_o,
  input wire             access_fault_o,
  input wire             privilege_bit_o,
  input wire             bank_select_bit_o,
  input wire             event_hold_flag_o,
  input wire             fpu_off_bit_o,
  input wire [3:0]       irq_level_mask_o,
  input wire [WIDTH-1:0] pc_o,
  input wire [WIDTH-1:0] fp_status_ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  wire priv_only = (ctl_sel_i >= `SEL_SAVED_STATUS) && (ctl_sel_i <= `SEL_DEBUG_BASE);
  wire req       = (ctl_rd_en_i || ctl_wr_en_i) && !manual_rst_i;
  wire sw_wr     = ctl_wr_en_i && (ctl_sel_i == `SEL_STATUS_WORD) && !manual_rst_i;

  status_reset_a: assert property (manual_rst_i |=> privilege_bit_o && bank_select_bit_o
    && event_hold_flag_o && !fpu_off_bit_o && irq_level_mask_o == 4'hF)
    else $error("status word not at reset value");
  sys_reset_a: assert property (manual_rst_i |=> pc_o == 32'hA0000000
    && fp_status_ctrl_o == 32'h00040001) else $error("pc or fp status not at reset value");
  user_refuse_a: assert property (ctl_rd_en_i && !privilege_bit_o && priv_only && !manual_rst_i
    |=> access_fault_o && ctl_rd_data_o == 32'h00000000) else $error("user read not refused");
  global_open_a: assert property (req && ctl_sel_i <= `SEL_GLOBAL_BASE
    |=> !access_fault_o) else $error("global base or status refused");
  system_open_a: assert property (req && ctl_sel_i >= `SEL_MAC_HIGH && ctl_sel_i <= `SEL_PC
    |=> !access_fault_o) else $error("system register refused");
  hidden_bits_a: assert property (sw_wr && !privilege_bit_o |=> $stable({privilege_bit_o,
    bank_select_bit_o, event_hold_flag_o, fpu_off_bit_o, irq_level_mask_o}))
    else $error("user write changed protected status bits");
  mode_bit_a: assert property (sw_wr && privilege_bit_o |=>
    privilege_bit_o == $past(ctl_wr_data_i[30]) && bank_select_bit_o == $past(ctl_wr_data_i[29]))
    else $error("mode or bank bit not taken from write");
  pc_write_a: assert property (req && ctl_wr_en_i && ctl_sel_i == `SEL_PC
    |=> pc_o == $past(ctl_wr_data_i)) else $error("pc write lost");
  alt_drop_a: assert property (alt_wr_en_i && !privilege_bit_o && !manual_rst_i
    |=> access_fault_o) else $error("user alternate bank write not refused");

  cover property (manual_rst_i);
  cover property (ctl_rd_en_i && !privilege_bit_o && priv_only);
  cover property (alt_wr_en_i && !privilege_bit_o);
endmodule // cpu_regs_checker

bind banked_cpu_register_file cpu_regs_checker #(.WIDTH(WIDTH)) i_cpu_regs_checker (.*);

//--- cpu_regs_map.vh
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH

// ----------------------------------------
// Control and system register selects
// ----------------------------------------
`define SEL_STATUS_WORD      4'h0
`define SEL_GLOBAL_BASE      4'h1
`define SEL_SAVED_STATUS     4'h2
`define SEL_SAVED_PC         4'h3
`define SEL_VECTOR_BASE      4'h4
`define SEL_SAVED_R15        4'h5
`define SEL_DEBUG_BASE       4'h6
`define SEL_MAC_HIGH         4'h7
`define SEL_MAC_LOW          4'h8
`define SEL_SUBROUTINE_LINK  4'h9
`define SEL_PC               4'hA
`define SEL_FP_CPU_TRANSFER  4'hB
`define SEL_FP_STATUS_CTRL   4'hC

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define SW_PRIVILEGE_BIT     30
`define SW_BANK_SELECT_BIT   29
`define SW_EVENT_HOLD_FLAG   28
`define SW_FPU_OFF_BIT       15
`define SW_IRQ_MASK_HI       7
`define SW_IRQ_MASK_LO       4
`define SW_USER_MASK         32'h00000303
`define SW_PRIV_MASK         32'h700083F3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_STATUS_WORD      32'h700000F0
`define RST_VECTOR_BASE      32'h00000000
`define RST_PC               32'hA0000000
`define RST_FP_STATUS_CTRL   32'h00040001

// ----------------------------------------
// Floating-point read views
// ----------------------------------------
`define FP_VIEW_SINGLE       2'h0
`define FP_VIEW_PAIR         2'h1
`define FP_VIEW_QUAD         2'h2

`endif

//--- decode_stub.sv
`timescale 1ns/100ps

module decode_stub #(
  parameter WIDTH = 32
) (
  // Clock
  input  wire             mclk_i,
  // Control port requests
  output reg  [3:0]       ctl_sel_o,
  output reg              ctl_rd_en_o,
  output reg              ctl_wr_en_o,
  output reg  [WIDTH-1:0] ctl_wr_data_o,
  // Control port answers
  input  wire [WIDTH-1:0] ctl_rd_data_i,
  input  wire             access_fault_i
);
  initial begin
    ctl_sel_o     = 4'hF;
    ctl_rd_en_o   = 1'b0;
    ctl_wr_en_o   = 1'b0;
    ctl_wr_data_o = 32'h5A5A5A5A;
  end

  // Idle data is inverted so a stale value can never pass for a fresh one
  task access(input wr, input [3:0] sel, input [WIDTH-1:0] data,
              output [WIDTH-1:0] rd, output fault);
    begin
      @(posedge mclk_i);
      #1;
      ctl_sel_o     = sel;
      ctl_wr_en_o   = wr;
      ctl_rd_en_o   = !wr;
      ctl_wr_data_o = data;
      @(posedge mclk_i);
      #1;
      rd            = ctl_rd_data_i;
      fault         = access_fault_i;
      ctl_rd_en_o   = 1'b0;
      ctl_wr_en_o   = 1'b0;
      ctl_wr_data_o = ~data;
    end
  endtask
endmodule // decode_stub

//--- fp_store.v
`timescale 1ns/100ps
`include "cpu_regs_map.vh"

// ----------------------------------------
// 32 single-precision words in four lanes
// ----------------------------------------
module fp_store #(
  parameter WIDTH = 32
) (
  // Clock
  input  wire               mclk_i,
  // Write: one word, or an even-aligned pair
  input  wire               wr_en_i,
  input  wire               wr_pair_i,
  input  wire [4:0]         wr_addr_i,
  input  wire [2*WIDTH-1:0] wr_data_i,
  // Read: a whole row of four lanes
  input  wire [2:0]         rd_row_i,
  output wire [4*WIDTH-1:0] rd_row_data_o
);

  genvar ln;
  generate
    for (ln = 0; ln < 4; ln = ln + 1) begin : g_lane
      reg  [WIDTH-1:0] mem [0:7];
      reg  [WIDTH-1:0] rd_q;
      wire             hit_single;
      wire             hit_pair;
      wire [WIDTH-1:0] wdata;
      assign hit_single = !wr_pair_i && (wr_addr_i[1:0] == ln);
      assign hit_pair   = wr_pair_i && (wr_addr_i[1] == (ln >= 2));
      // Pair: lower-numbered register takes the upper half
      assign wdata = (wr_pair_i && (ln % 2 == 0)) ? wr_data_i[2*WIDTH-1:WIDTH]
                                                  : wr_data_i[WIDTH-1:0];
      always @(posedge mclk_i) begin
        if (wr_en_i && (hit_single || hit_pair)) begin
          mem[wr_addr_i[4:2]] <= wdata;
        end
        rd_q <= mem[rd_row_i];
      end
      assign rd_row_data_o[(4-ln)*WIDTH-1 -: WIDTH] = rd_q;
    end
  endgenerate

endmodule // fp_store

//--- gpr_store.v
`timescale 1ns/100ps

// ----------------------------------------
// 24-word general register array, two read ports
// ----------------------------------------
module gpr_store #(
  parameter WIDTH = 32,
  parameter DEPTH = 24,
  parameter AW    = 5
) (
  // Clock
  input  wire             mclk_i,
  // Write port
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  // Read ports
  input  wire [AW-1:0]    rd_a_addr_i,
  output reg  [WIDTH-1:0] rd_a_data_o,
  input  wire [AW-1:0]    rd_b_addr_i,
  output reg  [WIDTH-1:0] rd_b_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Contents are left unreset on purpose
  always @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_a_data_o <= mem[rd_a_addr_i];
    rd_b_data_o <= mem[rd_b_addr_i];
  end

endmodule // gpr_store
